// File: verilog/psbsp_port.sv
// Operation
// - all inputs but drive permit captured on rising edge only
// - read data leaves through output registers
// - qualifier high holds access state; sleep and scan still run
// - select needs low, high, low together
// - advance steps counter, load starts access
// - each low lane mask writes byte+parity
// - data port is four nine-bit lanes
// - drive permit high floats the data pins
// - float on write data, deselect, resume
// - read returns word at previous edge address
// - incoming data captured into the write buffer
// - static strap picks interleaved or linear
// - sleep input enters retaining low power
// - back-to-back reads and writes, no waits
// - scan: sample on rise, shift out fall
// - burst steps two low bits, wraps
// - burst keeps direction latched at load
// - write data taken two edges after address
// - sleep entry and exit take two cycles
`timescale 1ns/1ps
`default_nettype none
`include "psbsp_cfg.svh"

module psbsp_port (
    input  wire logic                      clk_in,
    input  wire logic                      rst_n_in,
    input  wire logic [`PSBSP_ADDR_W-1:0]  addr_in,
    input  wire logic                      select_low_a_in,
    input  wire logic                      select_high_in,
    input  wire logic                      select_low_b_in,
    input  wire logic                      write_request_n_in,
    input  wire logic [`PSBSP_LANES-1:0]   lane_write_mask_n_in,
    input  wire logic                      advance_or_load_in,
    input  wire logic                      clock_qualify_n_in,
    input  wire logic [`PSBSP_DATA_W-1:0]  data_in,
    input  wire logic [`PSBSP_LANES-1:0]   parity_lines_in,
    output logic [`PSBSP_DATA_W-1:0]       data_out,
    output logic [`PSBSP_LANES-1:0]        parity_lines_out,
    output logic                           data_oe_out,
    input  wire logic                      drive_permit_n_in,
    input  wire logic                      burst_mode_in,
    input  wire logic                      sleep_request_in,
    output logic                           sleeping_out,
    input  wire logic                      tck_in,
    input  wire logic                      tms_in,
    input  wire logic                      tdi_in,
    output logic                           tdo_out
);
    // ************************************************************
    // declarations
    // ************************************************************
    psbsp_pkg::psbsp_state_s        st_r;
    psbsp_pkg::psbsp_state_s        st_nxt;
    psbsp_pkg::psbsp_beat_s         fifo_in;
    psbsp_pkg::psbsp_beat_s         fifo_out;
    logic [`PSBSP_WORD_W-1:0]       core_mem [0:`PSBSP_MEM_WORDS-1];
    logic [`PSBSP_WORD_W-1:0]       rd_word;
    logic [`PSBSP_WORD_W-1:0]       lanes_in;
    logic [1:0]                     cnt_step;
    logic                           selected;
    logic                           go;
    logic                           fifo_in_valid;
    logic                           fifo_in_ready;
    logic                           fifo_out_valid;
    logic                           fifo_out_ready;

    // burst order on the two low address bits
    function automatic logic [1:0] burst_lsb(input logic [1:0] base,
                                             input logic [1:0] cnt,
                                             input logic       inter);
        burst_lsb = inter ? (base ^ cnt) : (base + cnt);
    endfunction

    // ************************************************************
    // lane packing
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < `PSBSP_LANES; g++) begin : g_lane
            // lane word is parity above its byte
            assign lanes_in[g*`PSBSP_LANE_W +: `PSBSP_LANE_W] =
                {parity_lines_in[g], data_in[g*`PSBSP_BYTE_W +: `PSBSP_BYTE_W]};
            assign data_out[g*`PSBSP_BYTE_W +: `PSBSP_BYTE_W] =
                st_r.dout[g*`PSBSP_LANE_W +: `PSBSP_BYTE_W];
            assign parity_lines_out[g] =
                st_r.dout[g*`PSBSP_LANE_W + `PSBSP_BYTE_W];
        end
    endgenerate

    // ************************************************************
    // qualification and output drive
    // ************************************************************
    assign selected = !select_low_a_in && select_high_in && !select_low_b_in;
    assign cnt_step = st_r.burst_cnt + `PSBSP_BURST_STEP;
    assign go       = !clock_qualify_n_in && !st_r.asleep
                   && (fifo_in_ready || !st_r.s2_valid);
    assign rd_word  = core_mem[st_r.s1_addr];
    assign data_oe_out  = st_r.dout_oe && !drive_permit_n_in;
    assign sleeping_out = st_r.asleep;
    assign tdo_out      = st_r.tdo;

    // write beat enters the buffer at its data edge
    assign fifo_in_valid  = go && st_r.s2_valid;
    assign fifo_in.addr   = st_r.s2_addr;
    assign fifo_in.word   = lanes_in;
    assign fifo_in.mask_n = st_r.s2_mask_n;
    // drain pauses once sleep is asked for
    assign fifo_out_ready = !sleep_request_in && !st_r.asleep;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        // sleep entry and exit after two steady cycles
        if (sleep_request_in != st_r.asleep) begin
            st_nxt.sleep_cnt = st_r.sleep_cnt + 2'h1;
            if (st_nxt.sleep_cnt == `PSBSP_SLEEP_CYC) begin
                st_nxt.asleep    = sleep_request_in;
                st_nxt.sleep_cnt = 2'h0;
            end
        end else begin
            st_nxt.sleep_cnt = 2'h0;
        end
        // scan port sampled on tck rise, driven on fall
        st_nxt.tck_prev = tck_in;
        if (tck_in && !st_r.tck_prev) begin
            st_nxt.scan_bit = tdi_in;
            st_nxt.tms_ones = tms_in ? st_r.tms_ones + `PSBSP_TAP_STEP : 3'h0;
            if (tms_in && st_r.tms_ones == `PSBSP_TAP_RST_CNT) begin
                st_nxt.scan_bit = 1'b0;
                st_nxt.tms_ones = 3'h0;
            end
        end
        if (!tck_in && st_r.tck_prev) begin
            st_nxt.tdo = st_r.scan_bit;
        end
        // sleeping: pending work dropped, pins floated
        if (st_r.asleep) begin
            st_nxt.s1_kind  = psbsp_pkg::PSBSP_ACC_NONE;
            st_nxt.s2_valid = 1'b0;
            st_nxt.burst_on = 1'b0;
            st_nxt.dout_oe  = 1'b0;
        end
        if (go) begin
            // data phase of the loaded access
            st_nxt.s2_valid = 1'b0;
            case (st_r.s1_kind)
                psbsp_pkg::PSBSP_ACC_READ: begin
                    st_nxt.dout    = rd_word;
                    st_nxt.dout_oe = 1'b1;
                end
                psbsp_pkg::PSBSP_ACC_WRITE: begin
                    st_nxt.dout_oe   = 1'b0;
                    st_nxt.s2_valid  = 1'b1;
                    st_nxt.s2_addr   = st_r.s1_addr;
                    st_nxt.s2_mask_n = st_r.s1_mask_n;
                end
                default: begin
                    st_nxt.dout_oe = 1'b0;
                end
            endcase
            // command phase
            if (advance_or_load_in) begin
                if (st_r.burst_on) begin
                    st_nxt.burst_cnt = cnt_step;
                    st_nxt.s1_kind   = st_r.burst_wr ? psbsp_pkg::PSBSP_ACC_WRITE
                                                     : psbsp_pkg::PSBSP_ACC_READ;
                    st_nxt.s1_addr   = {st_r.burst_base[`PSBSP_ADDR_W-1:2],
                                        burst_lsb(st_r.burst_base[1:0], cnt_step,
                                                  st_r.interleave)};
                    st_nxt.s1_mask_n = lane_write_mask_n_in;
                end else begin
                    st_nxt.s1_kind = psbsp_pkg::PSBSP_ACC_NONE;
                end
            end else if (selected) begin
                st_nxt.burst_on   = 1'b1;
                st_nxt.burst_wr   = !write_request_n_in;
                st_nxt.burst_base = addr_in;
                st_nxt.burst_cnt  = 2'h0;
                st_nxt.s1_kind    = write_request_n_in ? psbsp_pkg::PSBSP_ACC_READ
                                                       : psbsp_pkg::PSBSP_ACC_WRITE;
                st_nxt.s1_addr    = addr_in;
                st_nxt.s1_mask_n  = lane_write_mask_n_in;
            end else begin
                st_nxt.burst_on = 1'b0;
                st_nxt.s1_kind  = psbsp_pkg::PSBSP_ACC_NONE;
            end
        end
        if (!rst_n_in) begin
            st_nxt            = '0;
            st_nxt.s1_kind    = psbsp_pkg::PSBSP_ACC_NONE;
            st_nxt.interleave = burst_mode_in;
        end
    end

    always_ff @(posedge clk_in) begin
        st_r <= st_nxt;
    end

    // ************************************************************
    // write buffer and storage core
    // ************************************************************
    psbsp_fifo #(
        .WIDTH ($bits(psbsp_pkg::psbsp_beat_s)),
        .DEPTH (`PSBSP_FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (fifo_in_valid),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (fifo_in),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_out_ready),
        .out_data_out  (fifo_out)
    );

    // masked lanes stay unaltered
    always_ff @(posedge clk_in) begin
        if (fifo_out_valid && fifo_out_ready) begin
            for (int i = 0; i < `PSBSP_LANES; i++) begin
                if (!fifo_out.mask_n[i]) begin
                    core_mem[fifo_out.addr][i*`PSBSP_LANE_W +: `PSBSP_LANE_W] <=
                        fifo_out.word[i*`PSBSP_LANE_W +: `PSBSP_LANE_W];
                end
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_READ_DATA: assert property (
        go && st_r.s1_kind == psbsp_pkg::PSBSP_ACC_READ
        |=> st_r.dout_oe && st_r.dout == $past(rd_word))
        else $error("read data not from loaded address");
    AST_HOLD: assert property (
        clock_qualify_n_in |=> $stable(st_r.s1_kind) && $stable(st_r.dout)
                               && $stable(st_r.burst_cnt) && $stable(st_r.s2_valid))
        else $error("state moved on an unqualified edge");
    AST_SELECT: assert property (
        go && !advance_or_load_in && selected |=> st_r.s1_kind != psbsp_pkg::PSBSP_ACC_NONE)
        else $error("selected load did not start an access");
    AST_DESEL_FLOAT: assert property (
        go && !advance_or_load_in && !selected ##1 go |=> !data_oe_out)
        else $error("outputs driven after deselect");
    AST_WRITE_FLOAT: assert property (
        go && !advance_or_load_in && selected && !write_request_n_in
        ##1 go |=> !data_oe_out ##0 st_r.s2_valid)
        else $error("write data phase not floated");
    AST_BURST_WRAP: assert property (
        go && advance_or_load_in && st_r.burst_on
        |=> st_r.burst_cnt == 2'($past(st_r.burst_cnt) + 2'h1))
        else $error("burst counter did not step");
    AST_DIR_KEEP: assert property (
        go && advance_or_load_in |=> $stable(st_r.burst_wr))
        else $error("burst direction changed mid burst");
    AST_PERMIT: assert property (
        drive_permit_n_in |-> !data_oe_out)
        else $error("data pins driven without permit");
    AST_CAPTURE: assert property (
        go && st_r.s2_valid |-> fifo_in_valid && fifo_in.word == lanes_in)
        else $error("write data not captured");
    AST_SLEEP_IN: assert property (
        sleep_request_in [*2] |=> st_r.asleep)
        else $error("sleep not entered after two cycles");
    AST_SLEEP_OUT: assert property (
        st_r.asleep |-> !data_oe_out && st_r.s1_kind == psbsp_pkg::PSBSP_ACC_NONE)
        else $error("activity while asleep");
    AST_SCAN: assert property (
        tck_in && !st_r.tck_prev && !(tms_in && st_r.tms_ones == `PSBSP_TAP_RST_CNT)
        |=> st_r.scan_bit == $past(tdi_in))
        else $error("tdi not sampled on tck rise");

    COV_WRITE_READ: cover property (
        go && st_r.s1_kind == psbsp_pkg::PSBSP_ACC_WRITE
        ##1 go && st_r.s1_kind == psbsp_pkg::PSBSP_ACC_READ);
    COV_BURST4: cover property (
        go && advance_or_load_in && st_r.burst_on && st_r.burst_cnt == 2'h3);
    COV_SLEEP: cover property ($rose(st_r.asleep));
    COV_QUAL_HOLD: cover property (st_r.dout_oe ##1 clock_qualify_n_in [*2]);
endmodule

`default_nettype wire

// File: verilog/psbsp_cfg.svh
`ifndef PSBSP_CFG_SVH
`define PSBSP_CFG_SVH

// ****************************************************************
// port geometry
// ****************************************************************
`define PSBSP_ADDR_W      20
`define PSBSP_LANES       4
`define PSBSP_BYTE_W      8
`define PSBSP_LANE_W      9
`define PSBSP_DATA_W      32
`define PSBSP_WORD_W      36
`define PSBSP_MEM_WORDS   1048576

// ****************************************************************
// buffering, burst and timing
// ****************************************************************
`define PSBSP_FIFO_DEPTH  16
`define PSBSP_BURST_STEP  2'h1
`define PSBSP_SLEEP_CYC   2'h2
`define PSBSP_TAP_RST_CNT 3'h5
`define PSBSP_TAP_STEP    3'h1

`endif

// File: verilog/psbsp_pkg.sv
`include "psbsp_cfg.svh"

package psbsp_pkg;

    // ************************************************************
    // access kinds and carriers
    // ************************************************************
    typedef enum logic [1:0] {
        PSBSP_ACC_NONE,
        PSBSP_ACC_READ,
        PSBSP_ACC_WRITE
    } psbsp_acc_e;

    // one write beat on its way into the core
    typedef struct packed {
        logic [`PSBSP_ADDR_W-1:0] addr;
        logic [`PSBSP_WORD_W-1:0] word;
        logic [`PSBSP_LANES-1:0]  mask_n;
    } psbsp_beat_s;

    // whole state of the port
    typedef struct packed {
        psbsp_acc_e               s1_kind;
        logic [`PSBSP_ADDR_W-1:0] s1_addr;
        logic [`PSBSP_LANES-1:0]  s1_mask_n;
        logic                     s2_valid;
        logic [`PSBSP_ADDR_W-1:0] s2_addr;
        logic [`PSBSP_LANES-1:0]  s2_mask_n;
        logic                     burst_on;
        logic                     burst_wr;
        logic [`PSBSP_ADDR_W-1:0] burst_base;
        logic [1:0]               burst_cnt;
        logic [`PSBSP_WORD_W-1:0] dout;
        logic                     dout_oe;
        logic                     interleave;
        logic [1:0]               sleep_cnt;
        logic                     asleep;
        logic                     tck_prev;
        logic                     scan_bit;
        logic                     tdo;
        logic [2:0]               tms_ones;
    } psbsp_state_s;

endpackage

// File: verilog/psbsp_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module psbsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [PW:0]                 count;
    } psbsp_fifo_s;

    psbsp_fifo_s st_r;
    psbsp_fifo_s st_nxt;
    logic        push;
    logic        pop;

    // honest full and empty from the fill count
    assign in_ready_out  = (st_r.count != DEPTH[PW:0]);
    assign out_valid_out = (st_r.count != '0);
    assign out_data_out  = st_r.mem[st_r.rd_ptr];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    // pointer and storage update
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wr_ptr] = in_data_in;
            st_nxt.wr_ptr = (st_r.wr_ptr == PW'(DEPTH - 1)) ? '0 : st_r.wr_ptr + 1'b1;
        end
        if (pop) begin
            st_nxt.rd_ptr = (st_r.rd_ptr == PW'(DEPTH - 1)) ? '0 : st_r.rd_ptr + 1'b1;
        end
        st_nxt.count = st_r.count + (PW+1)'(push) - (PW+1)'(pop);
        if (!rst_n_in) begin
            st_nxt.wr_ptr = '0;
            st_nxt.rd_ptr = '0;
            st_nxt.count  = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        st_r <= st_nxt;
    end
endmodule

`default_nettype wire

// File: dv/psbsp_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "psbsp_cfg.svh"

// ******************************************
// memory controller model: commands and write data
// ******************************************
module psbsp_ctrl_model (
    output logic [`PSBSP_ADDR_W-1:0] addr_out,
    output logic [2:0]               sel_out,
    output logic                     write_request_n_out,
    output logic [`PSBSP_LANES-1:0]  mask_n_out,
    output logic                     advance_or_load_out,
    output logic                     clock_qualify_n_out,
    output logic [`PSBSP_WORD_W-1:0] word_out
);
    logic [`PSBSP_WORD_W-1:0] p1_word;
    logic [`PSBSP_WORD_W-1:0] p2_word;
    logic                     p1_vld;
    logic                     p2_vld;
    logic                     drv;

    // start deselected with the data lines released
    initial begin
        addr_out            = '0;
        sel_out             = 3'h0;
        write_request_n_out = 1'b1;
        mask_n_out          = '1;
        advance_or_load_out = 1'b0;
        clock_qualify_n_out = 1'b0;
        word_out            = '0;
        p1_vld              = 1'b0;
        p2_vld              = 1'b0;
        drv                 = 1'b0;
    end

    // one command per call, made by the caller just after a falling edge
    task automatic issue(input logic [2:0] kind, input logic [`PSBSP_ADDR_W-1:0] addr,
                         input logic [2:0] sel, input logic [`PSBSP_LANES-1:0] mask,
                         input logic wbeat, input logic [`PSBSP_WORD_W-1:0] word);
        clock_qualify_n_out = (kind == 3'h4);
        if (kind != 3'h4) begin
            addr_out            = addr;
            sel_out             = sel;
            mask_n_out          = mask;
            write_request_n_out = (kind != 3'h1);
            advance_or_load_out = (kind == 3'h2);
            // write data goes out two qualified edges after its command
            drv      = p2_vld;
            word_out = drv ? p2_word : ~word_out;
            p2_word  = p1_word;
            p2_vld   = p1_vld;
            p1_word  = word;
            p1_vld   = wbeat;
        end else if (!drv) begin
            word_out = ~word_out; // released lines never keep a value
        end
    endtask
endmodule
`default_nettype wire

// File: dv/pipelined_burst_sram_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "psbsp_cfg.svh"

module pipelined_burst_sram_port_tb_top;
    typedef struct packed {
        logic [2:0]                kind;
        logic [`PSBSP_ADDR_W-1:0]  a;
        logic [2:0]                sel;
        logic [`PSBSP_LANES-1:0]   m;
        logic [`PSBSP_WORD_W-1:0]  w;
        logic                      oe;
    } psbsp_row_s;
    localparam logic [2:0] k_rd = 3'h0, k_wr = 3'h1, k_adv = 3'h2, k_des = 3'h3, k_hold = 3'h4;

    logic clk, rst_n, permit_n, mode, sleep_req, tck, tms, tdi, sleeping, tdo, oe;
    logic wr_n, adv, cqn;
    logic [`PSBSP_ADDR_W-1:0]  addr, exp_a, lq_a, b_base;
    logic [2:0]                sel;
    logic [1:0]                b_cnt;
    logic [`PSBSP_LANES-1:0]   mask_n, pout;
    logic [`PSBSP_DATA_W-1:0]  dout;
    logic [`PSBSP_WORD_W-1:0]  cword, bus;
    logic [`PSBSP_WORD_W-1:0]  shadow [logic [`PSBSP_ADDR_W-1:0]];
    logic                      exp_rd, lq_rd, b_open, b_wr;
    psbsp_row_s                rows [23];
    int                        n_fail, checks_done, cyc;

    // ******************************************
    // design and controller model
    // ******************************************
    assign bus = oe ? {pout, dout} : cword;
    psbsp_ctrl_model mdl (.addr_out(addr), .sel_out(sel), .write_request_n_out(wr_n),
        .mask_n_out(mask_n), .advance_or_load_out(adv), .clock_qualify_n_out(cqn),
        .word_out(cword));
    psbsp_port uut (.clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .select_low_a_in(sel[2]),
        .select_high_in(sel[1]), .select_low_b_in(sel[0]), .write_request_n_in(wr_n),
        .lane_write_mask_n_in(mask_n), .advance_or_load_in(adv), .clock_qualify_n_in(cqn),
        .data_in(bus[31:0]), .parity_lines_in(bus[35:32]), .data_out(dout),
        .parity_lines_out(pout), .data_oe_out(oe), .drive_permit_n_in(permit_n),
        .burst_mode_in(mode), .sleep_request_in(sleep_req), .sleeping_out(sleeping),
        .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo));

    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail = n_fail + 1;
            tally_and_finish();
        end
    end

    // ******************************************
    // compare, command and closing tasks
    // ******************************************
    task automatic cmp_bit(input logic exp, input logic got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: want %0h got %0h", $time, exp, got);
        end
    endtask
    task automatic cmp_word(input logic [`PSBSP_WORD_W-1:0] exp, input logic [`PSBSP_WORD_W-1:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: want %0h got %0h", $time, exp, got);
        end
    endtask
    function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n, input logic [3:0] m);
        logic [35:0] r;
        r = o;
        for (int g = 0; g < 4; g++) begin
            if (!m[g]) begin
                r[8*g +: 8] = n[8*g +: 8];
                r[32+g]     = n[32+g];
            end
        end
        return r;
    endfunction
    // check what the last edge left, then present the next command
    task automatic op(input psbsp_row_s r);
        logic                     q;
        logic                     ld;
        logic                     beat;
        logic [`PSBSP_ADDR_W-1:0] ea;
        @(negedge clk);
        cmp_bit(r.oe, oe);
        if (exp_rd) cmp_word(shadow[exp_a], bus);
        q  = (r.kind != k_hold);
        ld = (r.kind <= k_wr);
        if (ld) begin
            b_open = (r.sel == 3'h2);
            b_wr   = r.kind[0];
            b_base = r.a;
            b_cnt  = 2'h0;
        end else if (r.kind == k_adv) begin
            b_cnt = b_cnt + 2'h1;
        end else if (r.kind == k_des) begin
            b_open = 1'b0;
        end
        beat = q && b_open && (ld || r.kind == k_adv);
        ea   = {b_base[19:2], mode ? b_base[1:0] ^ b_cnt : b_base[1:0] + b_cnt};
        if (beat && b_wr) shadow[ea] = merge(shadow[ea], r.w, r.m);
        if (q) begin
            exp_rd = lq_rd;
            exp_a  = lq_a;
            lq_rd  = beat && !b_wr;
            lq_a   = ea;
        end
        mdl.issue(r.kind, r.a, r.sel, r.m, beat && b_wr, r.w);
    endtask
    task automatic cmd(input logic [2:0] k, input logic [19:0] a, input logic o);
        op('{k, a, (k == k_des) ? 3'h0 : 3'h2, 4'h0, 36'h0, o});
    endtask
    task automatic do_reset(input logic m);
        @(negedge clk);
        rst_n = 1'b0;
        mode  = m;
        repeat (8) @(negedge clk);
        rst_n  = 1'b1;
        exp_rd = 1'b0;
        lq_rd  = 1'b0;
        b_open = 1'b0;
    endtask
    task automatic scan_bit(input logic b);
        @(negedge clk);
        tdi = b;
        tck = 1'b1;
        repeat (3) @(negedge clk);
        cmp_bit(~b, tdo);
        tck = 1'b0;
        repeat (3) @(negedge clk);
        cmp_bit(b, tdo);
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ******************************************
    // main sequence
    // ******************************************
    initial begin
        {rst_n, permit_n, sleep_req, tck, tms, tdi} = 6'h0;
        {exp_rd, lq_rd, b_open, b_wr, mode} = 5'h1;
        {n_fail, checks_done, cyc} = '0;
        rows = '{'{k_wr, 20'h00010, 3'h2, 4'h0, 36'hA_0102_0304, 1'b0},
            '{k_wr, 20'h00020, 3'h2, 4'h0, 36'h5_1122_3344, 1'b0},
            '{k_wr, 20'h00030, 3'h2, 4'h0, 36'hF_5566_7788, 1'b0},
            '{k_wr, 20'h00030, 3'h2, 4'hA, 36'h0_99AA_BBCC, 1'b0},
            '{k_des, 20'h00000, 3'h0, 4'h0, 36'h0, 1'b0},
            '{k_rd, 20'h00010, 3'h2, 4'h0, 36'h0, 1'b0},
            '{k_rd, 20'h00020, 3'h2, 4'h0, 36'h0, 1'b0},
            '{k_wr, 20'h00040, 3'h2, 4'h0, 36'h3_DEAD_BEEF, 1'b1},
            '{k_rd, 20'h00030, 3'h2, 4'h0, 36'h0, 1'b1},
            '{k_wr, 20'h00051, 3'h2, 4'h0, 36'h1_0000_0001, 1'b0},
            '{k_adv, 20'h00000, 3'h0, 4'h0, 36'h2_0000_0002, 1'b1},
            '{k_adv, 20'h00000, 3'h0, 4'h0, 36'h3_0000_0003, 1'b0},
            '{k_adv, 20'h00000, 3'h0, 4'h0, 36'h4_0000_0004, 1'b0},
            '{k_des, 20'h00000, 3'h0, 4'h0, 36'h0, 1'b0},
            '{k_rd, 20'h00052, 3'h0, 4'h0, 36'h0, 1'b0},
            '{k_rd, 20'h00052, 3'h6, 4'h0, 36'h0, 1'b0},
            '{k_rd, 20'h00052, 3'h3, 4'h0, 36'h0, 1'b0},
            '{k_rd, 20'h00052, 3'h2, 4'h0, 36'h0, 1'b0},
            '{k_adv, 20'h00000, 3'h0, 4'h0, 36'h0, 1'b0},
            '{k_adv, 20'h00000, 3'h0, 4'h0, 36'h0, 1'b1},
            '{k_adv, 20'h00000, 3'h0, 4'h0, 36'h0, 1'b1},
            '{k_des, 20'h00000, 3'h0, 4'h0, 36'h0, 1'b1},
            '{k_des, 20'h00000, 3'h0, 4'h0, 36'h0, 1'b1}};
        do_reset(1'b1);
        cmp_bit(1'b0, sleeping);
        foreach (rows[i]) op(rows[i]);
        // qualifier held: read result waits, then stays put
        cmd(k_rd, 20'h00010, 1'b0);
        cmd(k_hold, 20'h0, 1'b0);
        cmd(k_hold, 20'h0, 1'b0);
        cmd(k_des, 20'h0, 1'b0);
        cmd(k_hold, 20'h0, 1'b1);
        cmd(k_hold, 20'h0, 1'b1);
        @(negedge clk);
        permit_n = 1'b1;
        #1 cmp_bit(1'b0, oe);
        permit_n = 1'b0;
        cmd(k_des, 20'h0, 1'b1);
        cmd(k_des, 20'h0, 1'b0);
        // sleep: two edges in, two edges out, contents kept
        sleep_req = 1'b1;
        @(negedge clk);
        cmp_bit(1'b0, sleeping);
        @(negedge clk);
        cmp_bit(1'b1, sleeping);
        repeat (4) @(negedge clk);
        sleep_req = 1'b0;
        @(negedge clk);
        cmp_bit(1'b1, sleeping);
        @(negedge clk);
        cmp_bit(1'b0, sleeping);
        cmd(k_rd, 20'h00040, 1'b0);
        cmd(k_des, 20'h0, 1'b0);
        cmd(k_des, 20'h0, 1'b1);
        scan_bit(1'b1);
        scan_bit(1'b0);
        // sixteen writes back to back through the buffer, then read back
        for (int j = 0; j < 34; j++) begin
            op('{(j < 16) ? k_wr : (j < 32) ? k_rd : k_des, {16'h0010, 4'(j)},
                (j < 32) ? 3'h2 : 3'h0, 4'h0, 36'h1_1111_1111 * 36'(j % 16), j >= 18});
        end
        // linear order after a reset with the strap low
        cmd(k_des, 20'h0, 1'b0);
        do_reset(1'b0);
        cmd(k_rd, 20'h00051, 1'b0);
        cmd(k_adv, 20'h0, 1'b0);
        cmd(k_adv, 20'h0, 1'b1);
        cmd(k_adv, 20'h0, 1'b1);
        cmd(k_des, 20'h0, 1'b1);
        cmd(k_des, 20'h0, 1'b1);
        cmd(k_des, 20'h0, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
